/* File: core/frame_scan_ctrl.v */
// frame triggered scan sequencer for a low power sense controller
// Operation
// R1 - scan starts only on a frame trigger after software armed all slots
// R2 - source holds each trigger pulse at least two slow oscillator cycles
// R3 - source spaces pulses beyond frame, interrupt and processing time
// R4 - source gives a clean rectangular trigger pulse
// R5 - a started scan runs to its end without processor help
// R6 - scan completion raises an interrupt that wakes from sleep
// R7 - hardware stays inactive during deep sleep
// R8 - a multi widget request wakes the processor after every widget
// R9 - source keeps trigger no longer than one scan frame
// R10 - at least two slow oscillator cycles between arming and trigger
// R11 - trigger is synchronised to slow oscillator, scan starts on qualified rise
`timescale 1ns/100ps
`default_nettype none
`include "frame_scan_consts.vh"
module frame_scan_ctrl
(
    input  wire                       ref_clk_i,
    input  wire                       srst_i,
    input  wire                       low_speed_osc_clock_i,
    input  wire                       frame_start_i,
    input  wire                       arm_all_slots_i,
    input  wire [`FS_SLOT_CNT_W-1:0]  slot_count_i,
    input  wire                       deep_sleep_i,
    input  wire                       slot_done_i,
    output reg                        slot_start_o,
    output reg  [`FS_SLOT_CNT_W-1:0]  slot_index_o,
    output reg                        busy_o,
    output reg                        armed_o,
    output reg                        wake_irq_o
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_ARM  = 4'h2;
    localparam [3:0] ST_SCAN = 4'h4;
    localparam [3:0] ST_WAIT = 4'h8;

    reg [3:0]                    state;
    reg [3:0]                    next_state;
    reg [`FS_LSO_SYNC_W-1:0]     lso_sync;
    reg                          lso_prev;
    reg [`FS_LSO_SYNC_W-1:0]     trig_sync;
    reg                          qualified;
    reg                          qual_prev;
    reg [`FS_LSO_CNT_W-1:0]      arm_gap;
    reg [`FS_SLOT_CNT_W-1:0]     slots_left;
    wire                         lso_rise;
    wire                         trig_launch;

    wire                         arm_ok;
    wire                         gap_met;
    wire                         slot_finish;
    wire                         last_slot;

    // slow oscillator is sampled, not used as a clock: one domain only
    assign lso_rise    = lso_sync[1] & ~lso_prev;
    // launch on the rise of the qualified level, so one long pulse starts one scan
    assign trig_launch = qualified & ~qual_prev; // R11
    assign arm_ok      = arm_all_slots_i & ~deep_sleep_i;
    assign gap_met     = (arm_gap == `FS_ARM_GAP_LSO);
    assign slot_finish = (state == ST_WAIT) & slot_done_i & ~deep_sleep_i;
    assign last_slot   = (slots_left == 8'h00);

    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            lso_sync  <= {`FS_LSO_SYNC_W{1'b0}};
            lso_prev  <= 1'b0;
        end
        else
        begin
            lso_sync  <= {lso_sync[0], low_speed_osc_clock_i};
            lso_prev  <= lso_sync[1];
        end
    end

    // the trigger is looked at only on slow rises: that is its synchronisation
    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            trig_sync <= {`FS_LSO_SYNC_W{1'b0}};
            qualified <= 1'b0;
            qual_prev <= 1'b0;
        end
        else
        begin
            qual_prev <= qualified;
            if (lso_rise)
                trig_sync <= {trig_sync[0], frame_start_i}; // R11
            // both slow samples high: a pulse of the minimum width is enough
            qualified <= &trig_sync; // R2
        end
    end

    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (arm_ok)
                    next_state = ST_ARM;
            end
            ST_ARM:
            begin
                // a trigger before the arm gap elapses is ignored
                if (deep_sleep_i)
                    next_state = ST_IDLE; // R7
                else if (trig_launch && gap_met)
                    next_state = ST_SCAN; // R1 R10
            end
            ST_SCAN:
            begin
                if (deep_sleep_i)
                    next_state = ST_IDLE; // R7
                else
                    next_state = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (deep_sleep_i)
                    next_state = ST_IDLE; // R7
                else if (slot_done_i)
                    next_state = last_slot ? ST_IDLE : ST_SCAN; // R5
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // arm gap counts slow rises seen while armed, saturating at the minimum
    always @(posedge ref_clk_i)
    begin
        if (srst_i)
            arm_gap <= {`FS_LSO_CNT_W{1'b0}};
        else if (state != ST_ARM)
            arm_gap <= {`FS_LSO_CNT_W{1'b0}};
        else if (lso_rise && !gap_met)
            arm_gap <= arm_gap + 2'h1; // R10
    end

    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            slots_left   <= 8'h00;
            slot_index_o <= 8'h00;
        end
        else if (state == ST_IDLE)
        begin
            // a count of zero still scans one slot
            slot_index_o <= 8'h00;
            slots_left   <= (slot_count_i == 8'h00) ? 8'h00 : slot_count_i - 8'h01;
        end
        else if (slot_finish && !last_slot)
        begin
            slots_left   <= slots_left - 8'h01;
            slot_index_o <= slot_index_o + 8'h01;
        end
    end

    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            slot_start_o <= 1'b0;
        end
        else
        begin
            slot_start_o <= (next_state == ST_SCAN); // R5
        end
    end

    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            busy_o <= 1'b0;
        end
        else
        begin
            busy_o <= (next_state == ST_SCAN) || (next_state == ST_WAIT);
        end
    end

    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            armed_o <= 1'b0;
        end
        else
        begin
            armed_o <= (next_state == ST_ARM);
        end
    end

    // one wake pulse per finished widget, not only the last
    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            wake_irq_o <= 1'b0;
        end
        else
        begin
            wake_irq_o <= slot_finish; // R6 R8
        end
    end
endmodule // frame_scan_ctrl
`default_nettype wire

/* File: core/frame_scan_consts.vh */
// constants for the frame triggered scan controller
`ifndef FRAME_SCAN_CONSTS_VH
`define FRAME_SCAN_CONSTS_VH
`define FS_SLOT_CNT_W      8
`define FS_LSO_SYNC_W      2
`define FS_MIN_PULSE_LSO   2
`define FS_ARM_GAP_LSO     2
`define FS_LSO_CNT_W       2
`endif

/* File: test/frame_scan_ctrl_asserts.sv */
// checker on the frame scan controller ports
`timescale 1ns/100ps
`default_nettype none
module frame_scan_ctrl_asserts (
    input wire logic       ref_clk_i,
    input wire logic       srst_i,
    input wire logic       deep_sleep_i,
    input wire logic       slot_done_i,
    input wire logic       slot_start_o,
    input wire logic       busy_o,
    input wire logic       armed_o,
    input wire logic       wake_irq_o,
    input wire logic [7:0] slot_count_i,
    input wire logic [7:0] slot_index_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    // a done only counts while waiting, not in the cycle that starts the slot
    sequence s_done; busy_o && !slot_start_o && slot_done_i && !deep_sleep_i; endsequence
    chk_start_armed: assert property ($rose(busy_o) |-> $past(armed_o)) else $error("arm");
    chk_wake_done: assert property (s_done |=> wake_irq_o) else $error("wake");
    chk_wake_cause: assert property (wake_irq_o |-> $past(slot_done_i)) else $error("cause");
    chk_next_slot: assert property (s_done ##0 slot_index_o + 1 < slot_count_i |=> slot_start_o)
        else $error("slot");
    chk_start_once: assert property (slot_start_o |=> !slot_start_o) else $error("pulse");
    chk_sleep_idle: assert property (deep_sleep_i |=> !busy_o && !armed_o) else $error("sleep");
    chk_arm_gap: assert property ($rose(armed_o) |=> !busy_o [*6]) else $error("gap");
endmodule // frame_scan_ctrl_asserts
bind frame_scan_ctrl frame_scan_ctrl_asserts u_chk (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .deep_sleep_i(deep_sleep_i),
    .slot_done_i(slot_done_i), .slot_start_o(slot_start_o), .busy_o(busy_o),
    .armed_o(armed_o), .wake_irq_o(wake_irq_o), .slot_count_i(slot_count_i),
    .slot_index_o(slot_index_o));
`default_nettype wire

/* File: test/frame_sync_source.sv */
// frame sync pulse source facing the trigger input
`timescale 1ns/100ps
`default_nettype none
module frame_sync_source (
    input  wire logic osc_i,
    input  wire logic fire_i,
    output wire logic trig_o
);
    int left = 0;
    // whole slow cycles from an osc edge, so no glitch inside a pulse
    always @(posedge osc_i) left <= left ? left - 1 : (fire_i ? 3 : 0);
    assign trig_o = left != 0;
endmodule // frame_sync_source
`default_nettype wire

/* File: test/frame_scan_ctrl_bench.sv */
// self-checking bench for the frame scan controller
`timescale 1ns/100ps
`default_nettype none
module frame_scan_ctrl_bench;
    logic ref_clk_i = 0, srst_i = 1, low_speed_osc_clock_i = 0, arm_all_slots_i = 0;
    logic deep_sleep_i = 0, slot_done_i = 0, fire = 0;
    logic [7:0] slot_count_i = 8'h03;
    wire logic [7:0] slot_index_o;
    wire logic frame_start_i, slot_start_o, busy_o, armed_o, wake_irq_o;
    int err_count = 0, total_checks = 0;
    always #2.5 ref_clk_i = ~ref_clk_i;
    always #20 low_speed_osc_clock_i <= ~low_speed_osc_clock_i;
    frame_scan_ctrl dut (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .low_speed_osc_clock_i(low_speed_osc_clock_i),
        .frame_start_i(frame_start_i), .arm_all_slots_i(arm_all_slots_i),
        .slot_count_i(slot_count_i), .deep_sleep_i(deep_sleep_i), .slot_done_i(slot_done_i),
        .slot_start_o(slot_start_o), .slot_index_o(slot_index_o), .busy_o(busy_o),
        .armed_o(armed_o), .wake_irq_o(wake_irq_o));
    frame_sync_source src (.osc_i(low_speed_osc_clock_i), .fire_i(fire), .trig_o(frame_start_i));
    task tick; @(negedge ref_clk_i); endtask
    task check(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin err_count++; $display("ERROR %0t %s", $time, m); end
    endtask
    task report_and_stop;
        $display("%0d checks %0d errors", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task scan(input int n, input logic sleep);
        {slot_count_i, deep_sleep_i} = {n[7:0], sleep};
        arm_all_slots_i = 1; tick; arm_all_slots_i = 0;
        check(armed_o === !sleep, "armed");
        repeat (40) tick;
        fire = 1; repeat (8) tick; fire = 0;
        for (int i = 0; i < 40 && !slot_start_o; i++) tick;
        if (slot_start_o === sleep) begin check(0, "start"); report_and_stop; end
        for (int k = 0; k < (sleep ? 0 : n ? n : 1); k++) begin
            check(busy_o && slot_index_o === k[7:0], "slot");
            tick; // front end reports done only after the start cycle
            slot_done_i = 1; tick; slot_done_i = 0;
            check(wake_irq_o && slot_start_o == (k + 1 < n), "wake");
        end
        deep_sleep_i = 0;
        check(!busy_o && !armed_o, "idle");
        $display("scan %0d sleep %0d done", n, sleep);
    endtask
    initial begin
        repeat (8) tick;
        srst_i = 0;
        scan(3, 0); scan(0, 0); scan(1, 1);
        report_and_stop;
    end
endmodule // frame_scan_ctrl_bench
`default_nettype wire
